/* File: verilog/rst_ctl_pkg.sv */
/*
 Constants shared by the reset source controller: register address,
 bit positions, reset values and timing counts.
 Assumes a single 100 MHz controller clock.
*/
`default_nettype none

package rst_ctl_pkg;

   ////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLK_MHZ             = 100;
   localparam int CLK_LOSS_MIN_US     = 50;
   localparam int CLK_LOSS_TYP_US     = 350;
   localparam int CLK_LOSS_MAX_US     = 650;
   localparam int CLK_LOSS_MIN_CYC    = CLK_LOSS_MIN_US * CLK_MHZ;
   localparam int CLK_LOSS_TYP_CYC    = CLK_LOSS_TYP_US * CLK_MHZ;
   localparam int CLK_LOSS_MAX_CYC    = CLK_LOSS_MAX_US * CLK_MHZ;
   localparam int RESET_DELAY_MAX_US  = 180;
   localparam int RESET_DELAY_MAX_CYC = RESET_DELAY_MAX_US * CLK_MHZ;
   localparam int PIN_LOW_MIN_US      = 20;
   localparam int PIN_FILT_NS         = 1000;
   localparam int PIN_FILT_CYC_DEF    = (PIN_FILT_NS * CLK_MHZ) / 1000;
   localparam int WDT_DIV             = 12;
   localparam int CNT_W               = 17;

   ////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [7:0] CAUSE_ADDR  = 8'hef;
   localparam int BIT_PIN             = 0;
   localparam int BIT_POR             = 1;
   localparam int BIT_MCD             = 2;
   localparam int BIT_WDT             = 3;
   localparam int BIT_SW              = 4;
   localparam int BIT_CMP             = 5;
   localparam int BIT_FE              = 6;
   localparam int BIT_RTC             = 7;
   localparam logic [7:0] CAUSE_RST   = 8'h02;

   ////////////////////////////////////////////////////////////////////
   // Synchroniser lanes
   localparam int SY_CLK              = 0;
   localparam int SY_CMP              = 1;
   localparam int SY_SUP              = 2;
   localparam int SY_PIN              = 3;
   localparam int SY_OSC              = 4;
   localparam int SY_ALM              = 5;
   localparam int SY_W                = 6;
   localparam logic [5:0] SYNC_INIT   = 6'h0a;

   typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_DELAY} state_t;

endpackage

`default_nettype wire

/* File: verilog/sync_two_ff.sv */
/*
 Two flip-flop synchroniser for a bus of independent levels.
 Assumes each lane is a slow level; no lane relation is kept.
*/
`timescale 1ns/1ps
`default_nettype none

module sync_two_ff #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta_ff;

   // First stage is read only by the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= INIT;
         dout    <= INIT;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end

endmodule

`default_nettype wire

/* File: verilog/reset_source_controller.sv */
/*
 Reset source controller: gathers reset requests, holds the system in
 reset, releases it after a fixed delay and records the last cause in
 the reset_cause_and_enable register at 0xef.
 Assumes rst is the power-on reset; all request inputs except the
 synchronised pins are on clk.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Enabled clock-loss detector resets the system when the clock stalls.
// - Clock-loss timeout counted from last rising edge, typical value default.
// - Bit 2 write enables/disables clock-loss detector; reads its cause flag.
// - Bit 5 enables comparator reset; low comparator output holds reset.
// - After any reset the watchdog is enabled, ticking at clock over twelve.
// - Watchdog timeout resets and sets read-only cause bit 3.
// - Program-store write above lock byte causes flash-error reset.
// - Code read or fetch above lock byte causes flash-error reset.
// - Security block, or flash write with supply monitor off, is flash error.
// - Bit 6 reads one only after a flash-error reset.
// - Clock-unit oscillator fail or alarm raises a reset request.
// - Clock-unit requests act only when bit 7 enabled; bit 7 reads cause.
// - Writing one to bit 4 forces reset, then bit 4 reads one.
// - Bit 1 set on power-on; writes enable supply monitor as source.
// - Power-on flag set means other flags are meaningless.
// - Bit 0 reads one only after an external pin reset.
// - Read-modify-write reads return stored enables; bits 0, 3 and 6 still read cause flags.
// - Internal resets other than the supply monitor never drive the external reset pin.
// - Execution resumes within the maximum delay after release.
// - Power-on flag cleared by every other kind of reset; a supply-monitor reset sets it instead.
// - Supply monitor source set by power-on, kept by other resets.
module reset_source_controller
   import rst_ctl_pkg::*;
#(
   parameter int CLK_LOSS_CYC = CLK_LOSS_TYP_CYC,
   parameter int RELEASE_CYC  = RESET_DELAY_MAX_CYC,
   parameter int PIN_FILT_CYC = PIN_FILT_CYC_DEF
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic        sfr_rmw,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   input  wire logic        system_clock_signal,
   input  wire logic        comparator_out,
   input  wire logic        supply_low,
   input  wire logic        supply_mon_on,
   input  wire logic        reset_pin_n_in,
   output logic             reset_pin_n_out,
   output logic             reset_pin_n_oe,
   input  wire logic        rtc_osc_fail,
   input  wire logic        rtc_alarm,
   input  wire logic        watchdog_timeout,
   input  wire logic        watchdog_disable,
   output logic             watchdog_enable,
   output logic             watchdog_tick,
   input  wire logic        program_store_write_enable,
   input  wire logic        flash_write_try,
   input  wire logic        code_space_read,
   input  wire logic        fetch_try,
   input  wire logic [15:0] flash_addr,
   input  wire logic [15:0] lock_addr,
   input  wire logic        security_block,
   output logic             supply_reset_source,
   output logic             sys_reset,
   output logic             cpu_run
);

   ////////////////////////////////////////////////////////////////////
   // Synchronised pins
   logic [SY_W-1:0] sy;
   logic            clk_mon_d_ff;
   logic            clk_rise;

   sync_two_ff #(
      .W    (SY_W),
      .INIT (SYNC_INIT)
   ) i_sync_two_ff (
      .clk  (clk),
      .rst  (rst),
      .din  ({rtc_alarm, rtc_osc_fail, reset_pin_n_in, supply_low, comparator_out, system_clock_signal}),
      .dout (sy)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_mon_d_ff <= 1'b0;
      end else begin
         clk_mon_d_ff <= sy[SY_CLK];
      end
   end

   assign clk_rise = sy[SY_CLK] & ~clk_mon_d_ff;

   ////////////////////////////////////////////////////////////////////
   // Stored enables
   logic    mcd_en_ff;
   logic    cmp_en_ff;
   logic    rtc_en_ff;
   logic    sup_src_ff;
   logic    sw_req_ff;
   logic    hit_wr;
   logic    hit_rd;
   state_t  state_ff;

   assign hit_wr = sfr_wr & (sfr_addr == CAUSE_ADDR);
   assign hit_rd = sfr_rd & (sfr_addr == CAUSE_ADDR);

   // Enables survive internal resets; only power-on resets them, setting the supply source to one
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mcd_en_ff  <= 1'b0;
         cmp_en_ff  <= 1'b0;
         rtc_en_ff  <= 1'b0;
         sup_src_ff <= 1'b1;
      end else if (hit_wr) begin
         mcd_en_ff  <= sfr_wdata[BIT_MCD];
         cmp_en_ff  <= sfr_wdata[BIT_CMP];
         rtc_en_ff  <= sfr_wdata[BIT_RTC];
         sup_src_ff <= sfr_wdata[BIT_POR];
      end
   end

   // Software force is a one-cycle request; writing zero does nothing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sw_req_ff <= 1'b0;
      end else begin
         sw_req_ff <= hit_wr & sfr_wdata[BIT_SW] & (state_ff == ST_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Clock-loss detector
   logic [CNT_W-1:0] loss_cnt_ff;
   logic             loss_ff;

   // Lost state holds reset until the clock rises again
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         loss_cnt_ff <= '0;
         loss_ff     <= 1'b0;
      end else if (!mcd_en_ff || clk_rise) begin
         loss_cnt_ff <= '0;
         loss_ff     <= 1'b0;
      end else if (loss_cnt_ff == CNT_W'(CLK_LOSS_CYC - 1)) begin
         loss_ff     <= 1'b1;
      end else begin
         loss_cnt_ff <= loss_cnt_ff + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin filter: shorter than the guaranteed low time, rejects noise
   logic [CNT_W-1:0] pin_cnt_ff;
   logic             pin_low_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_cnt_ff <= '0;
         pin_low_ff <= 1'b0;
      end else if (sy[SY_PIN]) begin
         pin_cnt_ff <= '0;
         pin_low_ff <= 1'b0;
      end else if (pin_cnt_ff == CNT_W'(PIN_FILT_CYC - 1)) begin
         pin_low_ff <= 1'b1;
      end else begin
         pin_cnt_ff <= pin_cnt_ff + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Request collection
   logic above_lock;
   logic req_pin;
   logic req_por;
   logic req_mcd;
   logic req_cmp;
   logic req_wdt;
   logic req_fe;
   logic req_rtc;
   logic req_sw;
   logic any_req;

   assign above_lock = flash_addr > lock_addr;
   assign req_pin    = pin_low_ff;
   assign req_por    = sup_src_ff & supply_mon_on & sy[SY_SUP];
   assign req_mcd    = loss_ff;
   assign req_cmp    = cmp_en_ff & ~sy[SY_CMP];
   assign req_wdt    = watchdog_timeout & watchdog_enable;
   assign req_rtc    = rtc_en_ff & (sy[SY_OSC] | sy[SY_ALM]);
   assign req_sw     = sw_req_ff;
   assign req_fe     = (flash_write_try & program_store_write_enable & above_lock)
                     | (code_space_read & above_lock)
                     | (fetch_try & above_lock)
                     | security_block
                     | (flash_write_try & program_store_write_enable & ~supply_mon_on);
   assign any_req    = req_pin | req_por | req_mcd | req_cmp | req_wdt | req_fe | req_rtc | req_sw;

   // Fixed priority keeps exactly one cause per reset
   function automatic logic [7:0] pick_cause(input logic [7:0] r);
      logic [7:0] c;
      c = 8'h00;
      if (r[BIT_POR]) begin
         c[BIT_POR] = 1'b1;
      end else if (r[BIT_PIN]) begin
         c[BIT_PIN] = 1'b1;
      end else if (r[BIT_MCD]) begin
         c[BIT_MCD] = 1'b1;
      end else if (r[BIT_CMP]) begin
         c[BIT_CMP] = 1'b1;
      end else if (r[BIT_WDT]) begin
         c[BIT_WDT] = 1'b1;
      end else if (r[BIT_FE]) begin
         c[BIT_FE] = 1'b1;
      end else if (r[BIT_RTC]) begin
         c[BIT_RTC] = 1'b1;
      end else if (r[BIT_SW]) begin
         c[BIT_SW] = 1'b1;
      end
      return c;
   endfunction

   logic [7:0] req_vec;

   always_comb begin
      req_vec          = 8'h00;
      req_vec[BIT_PIN] = req_pin;
      req_vec[BIT_POR] = req_por;
      req_vec[BIT_MCD] = req_mcd;
      req_vec[BIT_WDT] = req_wdt;
      req_vec[BIT_SW]  = req_sw;
      req_vec[BIT_CMP] = req_cmp;
      req_vec[BIT_FE]  = req_fe;
      req_vec[BIT_RTC] = req_rtc;
   end

   ////////////////////////////////////////////////////////////////////
   // Reset sequencing
   state_t           nxt_state;
   logic [CNT_W-1:0] dly_cnt_ff;
   logic [7:0]       cause_ff;
   logic [7:0]       flags_ff;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_RUN: begin
            if (any_req) begin
               nxt_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!any_req) begin
               nxt_state = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (any_req) begin
               nxt_state = ST_HOLD;
            end else if (dly_cnt_ff == CNT_W'(RELEASE_CYC - 1)) begin
               nxt_state = ST_RUN;
            end
         end
         default: begin
            nxt_state = ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_DELAY;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dly_cnt_ff <= '0;
      end else if (state_ff == ST_DELAY && !any_req) begin
         dly_cnt_ff <= dly_cnt_ff + 1'b1;
      end else begin
         dly_cnt_ff <= '0;
      end
   end

   // A new request in the delay restarts capture; cause is the first of the last hold
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cause_ff <= CAUSE_RST;
      end else if (any_req && state_ff != ST_HOLD) begin
         cause_ff <= pick_cause(req_vec);
      end
   end

   // Flags change only on exit from reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_ff <= CAUSE_RST;
      end else if (state_ff == ST_DELAY && nxt_state == ST_RUN) begin
         flags_ff <= cause_ff;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sys_reset <= 1'b1;
         cpu_run   <= 1'b0;
      end else begin
         sys_reset <= (nxt_state != ST_RUN);
         cpu_run   <= (nxt_state == ST_RUN);
      end
   end

   // Only power-on and supply-monitor resets pull the pin low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reset_pin_n_oe  <= 1'b1;
         reset_pin_n_out <= 1'b0;
      end else begin
         reset_pin_n_oe  <= (nxt_state != ST_RUN) && (any_req && state_ff != ST_HOLD ?
                            req_por : cause_ff[BIT_POR]);
         reset_pin_n_out <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         supply_reset_source <= 1'b1;
      end else begin
         supply_reset_source <= hit_wr ? sfr_wdata[BIT_POR] : sup_src_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Watchdog enable and divide-by-twelve tick
   logic [3:0] wdt_div_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         watchdog_enable <= 1'b1;
      end else if (state_ff != ST_RUN) begin
         watchdog_enable <= 1'b1;
      end else if (watchdog_disable) begin
         watchdog_enable <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wdt_div_ff    <= '0;
         watchdog_tick <= 1'b0;
      end else if (state_ff != ST_RUN) begin
         wdt_div_ff    <= '0;
         watchdog_tick <= 1'b0;
      end else if (wdt_div_ff == 4'(WDT_DIV - 1)) begin
         wdt_div_ff    <= '0;
         watchdog_tick <= 1'b1;
      end else begin
         wdt_div_ff    <= wdt_div_ff + 1'b1;
         watchdog_tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register read
   logic [7:0] enable_view;

   always_comb begin
      enable_view          = flags_ff;
      enable_view[BIT_RTC] = rtc_en_ff;
      enable_view[BIT_CMP] = cmp_en_ff;
      enable_view[BIT_SW]  = 1'b0;
      enable_view[BIT_MCD] = mcd_en_ff;
      enable_view[BIT_POR] = sup_src_ff;
   end

   // Unmapped reads return zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else if (hit_rd) begin
         sfr_rdata <= sfr_rmw ? enable_view : flags_ff;
      end else begin
         sfr_rdata <= 8'h00;
      end
   end

endmodule

`default_nettype wire

/* File: testbench/reset_source_controller_props.sv */
/*
 Port checker for reset_source_controller, bound to every instance.
 Assumes one clock domain and rst as an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module rst_ctl_props
   import rst_ctl_pkg::*;
#(
   parameter int RELEASE_CYC = RESET_DELAY_MAX_CYC
) (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic       sfr_rmw,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic       watchdog_timeout,
   input wire logic       watchdog_enable,
   input wire logic       watchdog_tick,
   input wire logic       reset_pin_n_out,
   input wire logic       reset_pin_n_oe,
   input wire logic       sys_reset,
   input wire logic       cpu_run
);
   logic [15:0] hold_cnt_ff;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////
   // Length of the current reset, saturating so a stuck reset cannot wrap
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_cnt_ff <= 16'h0000;
      end else if (!sys_reset) begin
         hold_cnt_ff <= 16'h0000;
      end else if (hold_cnt_ff != 16'hffff) begin
         hold_cnt_ff <= hold_cnt_ff + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   sequence s_quiet;
      !watchdog_tick[*8] ##1 !watchdog_tick[*3];
   endsequence

   property p_sw_force;
      sfr_wr && sfr_addr == CAUSE_ADDR && sfr_wdata[BIT_SW] && cpu_run |-> ##2 sys_reset;
   endproperty
   a_sw_force: assert property (p_sw_force) else $error("software force gave no reset");

   property p_wdt_reset;
      watchdog_timeout && watchdog_enable && cpu_run |=> sys_reset && !cpu_run;
   endproperty
   a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog timeout gave no reset");

   property p_pin_drive;
      reset_pin_n_oe |-> sys_reset && !reset_pin_n_out;
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("pin driven outside reset");

   property p_release;
      $fell(sys_reset) |-> hold_cnt_ff >= RELEASE_CYC;
   endproperty
   a_release: assert property (p_release) else $error("reset released too early");

   property p_wdt_on;
      $fell(sys_reset) |-> watchdog_enable && cpu_run;
   endproperty
   a_wdt_on: assert property (p_wdt_on) else $error("watchdog off after reset");

   property p_tick_gap;
      watchdog_tick |=> s_quiet;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("watchdog tick faster than twelve");

   property p_rd_idle;
      !sfr_rd |=> sfr_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");

   property p_rmw_sw;
      sfr_rd && sfr_rmw && sfr_addr == CAUSE_ADDR |=> !sfr_rdata[BIT_SW];
   endproperty
   a_rmw_sw: assert property (p_rmw_sw) else $error("modify read shows force flag");
endmodule

bind reset_source_controller rst_ctl_props #(.RELEASE_CYC(RELEASE_CYC)) i_rst_ctl_props (
   .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .watchdog_timeout(watchdog_timeout), .watchdog_enable(watchdog_enable),
   .watchdog_tick(watchdog_tick), .reset_pin_n_out(reset_pin_n_out),
   .reset_pin_n_oe(reset_pin_n_oe), .sys_reset(sys_reset), .cpu_run(cpu_run));

`default_nettype wire

/* File: testbench/rst_ctl_partner.sv */
/*
 Far-side model: the monitored system clock and the external reset circuit.
 Assumes clk is the controller clock and the pin has a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module rst_ctl_partner
   import rst_ctl_pkg::*;
#(
   parameter int PIN_LOW_CYC = PIN_LOW_MIN_US * CLK_MHZ
) (
   input  wire logic clk,
   input  wire logic clk_stop,
   input  wire logic pin_go,
   output logic      system_clock_signal,
   output logic      reset_pin_n
);
   logic [1:0] div_ff = 2'h0;
   int         low_cnt = 0;

   // A stopped clock freezes at its last level, either high or low
   always @(posedge clk) begin
      if (!clk_stop) begin
         div_ff <= div_ff + 2'h1;
      end
   end
   assign system_clock_signal = div_ff[1];

   always @(posedge clk) begin
      if (pin_go) begin
         low_cnt <= PIN_LOW_CYC;
      end else if (low_cnt > 0) begin
         low_cnt <= low_cnt - 1;
      end
   end
   // Released pin returns high through the pull-up
   assign reset_pin_n = (low_cnt == 0);
endmodule

`default_nettype wire

/* File: testbench/reset_source_controller_test.sv */
/*
 Self-checking bench for reset_source_controller with shortened counts.
 Assumes the checker is bound by its own file and the partner model is compiled.
*/
`timescale 1ns/1ps
`default_nettype none

module reset_source_controller_test;
   import rst_ctl_pkg::*;
   localparam int LOSS = 20;
   logic        clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
   logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic        comparator_out = 1'b1, supply_low = 1'b0, supply_mon_on = 1'b1;
   logic        rtc_osc_fail = 1'b0, rtc_alarm = 1'b0, watchdog_timeout = 1'b0, watchdog_disable = 1'b0;
   logic        program_store_write_enable = 1'b0, flash_write_try = 1'b0, code_space_read = 1'b0;
   logic        fetch_try = 1'b0, security_block = 1'b0, clk_stop = 1'b0, pin_go = 1'b0, oe_bad;
   logic [15:0] flash_addr = 16'h0000, lock_addr = 16'h7fff;
   logic        system_clock_signal, reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe;
   logic        watchdog_enable, watchdog_tick, supply_reset_source, sys_reset, cpu_run;
   logic [7:0]  q;
   int          n_fail = 0, checked = 0;

   initial begin
      forever #5 clk = ~clk;
   end

   reset_source_controller #(.CLK_LOSS_CYC(LOSS), .RELEASE_CYC(4), .PIN_FILT_CYC(2)) i_reset_source_controller (
      .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .system_clock_signal(system_clock_signal),
      .comparator_out(comparator_out), .supply_low(supply_low), .supply_mon_on(supply_mon_on),
      .reset_pin_n_in(reset_pin_n_in), .reset_pin_n_out(reset_pin_n_out), .reset_pin_n_oe(reset_pin_n_oe),
      .rtc_osc_fail(rtc_osc_fail), .rtc_alarm(rtc_alarm), .watchdog_timeout(watchdog_timeout),
      .watchdog_disable(watchdog_disable), .watchdog_enable(watchdog_enable), .watchdog_tick(watchdog_tick),
      .program_store_write_enable(program_store_write_enable), .flash_write_try(flash_write_try),
      .code_space_read(code_space_read), .fetch_try(fetch_try), .flash_addr(flash_addr),
      .lock_addr(lock_addr), .security_block(security_block), .supply_reset_source(supply_reset_source),
      .sys_reset(sys_reset), .cpu_run(cpu_run));

   rst_ctl_partner i_rst_ctl_partner (.clk(clk), .clk_stop(clk_stop), .pin_go(pin_go),
      .system_clock_signal(system_clock_signal), .reset_pin_n(reset_pin_n_in));

   ////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick(1);
      sfr_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic m);
      tick(1);
      sfr_addr = a;
      sfr_rmw = m;
      sfr_rd = 1'b1;
      tick(1);
      q = sfr_rdata;
      sfr_rd = 1'b0;
      sfr_rmw = 1'b0;
   endtask

   // Bounded wait for reset entry (lvl 1) or for running again (lvl 0)
   task automatic wait_for(input logic lvl);
      int n;
      n = 0;
      while ((lvl ? sys_reset : cpu_run) !== 1'b1) begin
         if (reset_pin_n_oe !== 1'b0) oe_bad = 1'b1;
         tick(1);
         n++;
         if (n > 3000) begin
            chk(8'h00, 8'h01, "wait ran out");
            tally_and_finish();
         end
      end
   endtask

   // Level requests are dropped once the reset is seen, as the sources would
   task automatic cause(input logic [7:0] exp);
      oe_bad = 1'b0;
      wait_for(1'b1);
      {rtc_alarm, rtc_osc_fail, watchdog_timeout, clk_stop} = 4'h0;
      comparator_out = 1'b1;
      wait_for(1'b0);
      rd(CAUSE_ADDR, 1'b0);
      chk(q, exp, "cause flags");
      chk({7'h0, oe_bad}, 8'h00, "pin driven");
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic t_por();
      int n;
      wait_for(1'b0);
      rd(CAUSE_ADDR, 1'b0);
      chk(q, CAUSE_RST, "power-on flags");
      rd(CAUSE_ADDR, 1'b1);
      chk(q, 8'h02, "modify read after power-on");
      chk({6'h0, supply_reset_source, watchdog_enable}, 8'h03, "power-on sources");
      wr(8'hee, 8'hff);
      rd(8'hee, 1'b0);
      chk(q, 8'h00, "unmapped read");
      tick(3);
      chk({7'h0, sys_reset}, 8'h00, "unmapped write reset");
      n = 0;
      repeat (24) begin
         tick(1);
         n += watchdog_tick;
      end
      chk(8'(n), 8'h02, "watchdog ticks");
   endtask

   task automatic t_sw_wdt();
      watchdog_disable = 1'b1;
      tick(1);
      watchdog_disable = 1'b0;
      chk({7'h0, watchdog_enable}, 8'h00, "watchdog off");
      wr(CAUSE_ADDR, 8'h12);
      cause(8'h10);
      chk({7'h0, watchdog_enable}, 8'h01, "watchdog on after reset");
      rd(CAUSE_ADDR, 1'b1);
      chk(q, 8'h02, "supply source kept");
      watchdog_timeout = 1'b1;
      cause(8'h08);
      chk({7'h0, watchdog_enable}, 8'h01, "watchdog on");
   endtask

   task automatic t_flash();
      fetch_try = 1'b1;
      flash_addr = lock_addr;
      tick(1);
      fetch_try = 1'b0;
      tick(8);
      chk({7'h0, sys_reset}, 8'h00, "fetch at lock byte");
      for (int k = 0; k < 5; k++) begin
         flash_addr = (k == 4) ? 16'h0100 : 16'h8000;
         supply_mon_on = (k != 4);
         program_store_write_enable = 1'b1;
         {flash_write_try, code_space_read, fetch_try, security_block} = {k == 0 || k == 4, k == 1, k == 2, k == 3};
         tick(1);
         {flash_write_try, code_space_read, fetch_try, security_block} = 4'h0;
         supply_mon_on = 1'b1;
         program_store_write_enable = 1'b0;
         cause(8'h40);
      end
   endtask

   task automatic t_rtc_cmp();
      rtc_alarm = 1'b1;
      comparator_out = 1'b0;
      tick(6);
      {rtc_alarm, comparator_out} = 2'b01;
      tick(6);
      chk({7'h0, sys_reset}, 8'h00, "disabled sources");
      wr(CAUSE_ADDR, 8'ha2);
      for (int k = 0; k < 2; k++) begin
         {rtc_osc_fail, rtc_alarm} = (k == 0) ? 2'b10 : 2'b01;
         cause(8'h80);
      end
      comparator_out = 1'b0;
      wait_for(1'b1);
      for (int k = 0; k < 10; k++) begin
         tick(1);
         chk({7'h0, sys_reset}, 8'h01, "comparator hold");
      end
      cause(8'h20);
      wr(CAUSE_ADDR, 8'h02);
   endtask

   task automatic t_mcd_pin();
      int n;
      wr(CAUSE_ADDR, 8'h06);
      tick(10);
      clk_stop = 1'b1;
      n = 0;
      while (sys_reset !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      chk({7'h0, n >= LOSS - 4 && n <= LOSS + 8}, 8'h01, "clock loss time");
      cause(8'h04);
      wr(CAUSE_ADDR, 8'h02);
      clk_stop = 1'b1;
      tick(3 * LOSS);
      chk({7'h0, sys_reset}, 8'h00, "detector off");
      clk_stop = 1'b0;
      pin_go = 1'b1;
      tick(1);
      pin_go = 1'b0;
      cause(8'h01);
      supply_low = 1'b1;
      wait_for(1'b1);
      tick(2);
      chk({7'h0, reset_pin_n_oe}, 8'h01, "supply reset pin drive");
      supply_low = 1'b0;
      wait_for(1'b0);
      rd(CAUSE_ADDR, 1'b0);
      chk(q, 8'h02, "supply flags");
   endtask

   initial begin
      tick(6);
      rst = 1'b0;
      t_por();
      t_sw_wdt();
      t_flash();
      t_rtc_cmp();
      t_mcd_pin();
      tally_and_finish();
   end
endmodule

`default_nettype wire
